// [logic/bcq_params.svh]
// Named constants for the queue push and flip opcode block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef BCQ_PARAMS_SVH
`define BCQ_PARAMS_SVH

// Opcode field width and opcode values
`define BCQ_OPW                 5
`define BCQ_OP_PUSH_TIME_UPPER  5'h19
`define BCQ_OP_PUSH_TIME_PAIR   5'h1A
`define BCQ_OP_PUSH_BLOCK_STAT  5'h11
`define BCQ_OP_PUSH_IMMEDIATE   5'h12
`define BCQ_OP_PUSH_INDIRECT    5'h13
`define BCQ_OP_WAIT_TRIGGER     5'h14
`define BCQ_OP_EXEC_FLIP_WAIT   5'h15
`define BCQ_OP_EXEC_FLIP_GO     5'h17

// Register offsets
`define BCQ_REG_GAP_COUNT       16'h0036
`define BCQ_REG_QUEUE_PTR       16'h0038
`define BCQ_REG_TIME_CONFIG     16'h0039
`define BCQ_REG_TIME_LOW        16'h0043
`define BCQ_REG_TIME_HIGH       16'h0044

// Fields and reset values
`define BCQ_WIDE_TIME_BIT       3
`define BCQ_FLIP_MASK           16'h0010
`define BCQ_CB_GAP_WORD         16'h0003
`define BCQ_QPTR_RESET          16'h00C0
`define BCQ_QDEPTH              64
`define BCQ_WORD_ZERO           16'h0000
`define BCQ_WORD_ONE            16'h0001
`define BCQ_WORD_ALL            16'hFFFF

// Message gap timer resolution (arbitrary plain default) and clock period
`define BCQ_GAP_LSB_NS          1000
`define BCQ_CLK_NS              50
`define BCQ_GAP_TICK_CYCLES     (`BCQ_GAP_LSB_NS / `BCQ_CLK_NS)

`endif

// [logic/bcq_pkg.sv]
// Types shared by the queue push and flip opcode block.
// Assumes nothing beyond a SystemVerilog compiler.
package bcq_pkg;

  // Sequencer states, one-hot
  typedef enum logic [11:0] {
    BCQ_ST_IDLE   = 12'h001,
    BCQ_ST_PUSH_A = 12'h002,
    BCQ_ST_PUSH_B = 12'h004,
    BCQ_ST_RDIND  = 12'h008,
    BCQ_ST_RDCB   = 12'h010,
    BCQ_ST_PREGAP = 12'h020,
    BCQ_ST_MSG    = 12'h040,
    BCQ_ST_WBACK  = 12'h080,
    BCQ_ST_GAPWT  = 12'h100,
    BCQ_ST_TRIG   = 12'h200,
    BCQ_ST_HALT   = 12'h400,
    BCQ_ST_SPARE  = 12'h800
  } bcq_state_t;

endpackage : bcq_pkg

// [logic/bcq_ctl_if.sv]
// Internal carrier between the opcode sequencer, gap timer and queue pointer.
// Assumes all three sit on the same clock.
`timescale 1ns/1ps
interface bcq_ctl_if;
  logic        gap_load;
  logic [15:0] gap_value;
  logic [15:0] gap_count;
  logic        gap_zero;
  logic        q_push;
  logic        q_host_wr;
  logic [15:0] q_host_data;
  logic [15:0] q_addr;
  logic [15:0] q_addr_next;
  logic        q_wrap;

  modport seq (output gap_load, gap_value, q_push, q_host_wr, q_host_data,
               input  gap_count, gap_zero, q_addr, q_addr_next, q_wrap);
  modport gap (input  gap_load, gap_value, output gap_count, gap_zero);
  modport que (input  q_push, q_host_wr, q_host_data,
               output q_addr, q_addr_next, q_wrap);
endinterface : bcq_ctl_if

// [logic/bcq_gap_timer.sv]
// Time-to-next-message countdown with its own resolution prescaler.
// Assumes the sequencer only loads nonzero values.
`timescale 1ns/1ps
`include "bcq_params.svh"
module bcq_gap_timer
  import bcq_pkg::*;
#(
  parameter int TICK_CYCLES = `BCQ_GAP_TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  bcq_ctl_if.gap    ctl
);
  logic [15:0] count_r;
  logic [15:0] presc_r;

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_chk
    $error("bcq_gap_timer: TICK_CYCLES out of range");
  end

  // Load restarts the prescaler so the first step is a full period
  always_ff @(posedge clk) begin
    if (srst) begin
      count_r <= `BCQ_WORD_ZERO;
      presc_r <= `BCQ_WORD_ZERO;
    end else if (ctl.gap_load) begin
      count_r <= ctl.gap_value;
      presc_r <= `BCQ_WORD_ZERO;
    end else if (count_r != `BCQ_WORD_ZERO) begin
      if (presc_r == 16'(TICK_CYCLES - 1)) begin
        presc_r <= `BCQ_WORD_ZERO;
        count_r <= count_r - `BCQ_WORD_ONE;
      end else begin
        presc_r <= presc_r + `BCQ_WORD_ONE;
      end
    end
  end

  assign ctl.gap_count = count_r;
  assign ctl.gap_zero  = (count_r == `BCQ_WORD_ZERO);
endmodule : bcq_gap_timer

// [logic/bcq_queue_ptr.sv]
// General purpose queue write pointer: circular over DEPTH words.
// Assumes a push is signalled once per word actually written to RAM.
`timescale 1ns/1ps
`include "bcq_params.svh"
module bcq_queue_ptr
  import bcq_pkg::*;
#(
  parameter int DEPTH = `BCQ_QDEPTH
) (
  input  wire logic clk,
  input  wire logic srst,
  bcq_ctl_if.que    ctl
);
  localparam int IW = $clog2(DEPTH);
  logic [15:0]   base_r;
  logic [IW-1:0] idx_r;
  logic          last;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("bcq_queue_ptr: DEPTH must be a power of two");
  end

  assign last = (idx_r == IW'(DEPTH - 1));

  // advance and wrap
  // Host relocation wins over a push in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      base_r <= `BCQ_QPTR_RESET;
      idx_r  <= '0;
    end else if (ctl.q_host_wr) begin
      base_r <= ctl.q_host_data;
      idx_r  <= '0;
    end else if (ctl.q_push) begin
      idx_r  <= last ? '0 : idx_r + IW'(1);
    end
  end

  assign ctl.q_addr      = base_r + 16'(idx_r);
  assign ctl.q_addr_next = last ? base_r : base_r + 16'(idx_r) + `BCQ_WORD_ONE;
  assign ctl.q_wrap      = ctl.q_push && last && !ctl.q_host_wr;
endmodule : bcq_queue_ptr

// [logic/bcq_exec.sv]
// Execution of the queue push, trigger wait and execute-and-flip opcodes.
// Assumes a sequencer that evaluates conditions, a single-port RAM with an
// acknowledge, and a message engine with start and done handshakes.
`timescale 1ns/1ps
`include "bcq_params.svh"
module bcq_exec
  import bcq_pkg::*;
#(
  parameter int QDEPTH      = `BCQ_QDEPTH,
  parameter int TICK_CYCLES = `BCQ_GAP_TICK_CYCLES
) (
  input  wire logic                CLK,
  input  wire logic                SRST,
  input  wire logic                OP_VALID,
  output logic                     OP_READY,
  input  wire logic [`BCQ_OPW-1:0] OP_CODE,
  input  wire logic [15:0]         OP_PARAM,
  input  wire logic [15:0]         OP_PARAM_ADDR,
  input  wire logic                COND_TRUE,
  output logic                     OP_DONE,
  output logic                     LIST_HALTED,
  input  wire logic                LIST_RESTART,
  input  wire logic                EXT_TRIGGER,
  output logic                     MEM_REQ,
  output logic                     MEM_WE,
  output logic [15:0]              MEM_ADDR,
  output logic [15:0]              MEM_WDATA,
  input  wire logic [15:0]         MEM_RDATA,
  input  wire logic                MEM_ACK,
  output logic                     MSG_START,
  output logic [15:0]              MSG_BLOCK_ADDR,
  input  wire logic                MSG_DONE,
  input  wire logic [15:0]         BLOCK_STATUS,
  output logic                     GAP_ZERO,
  input  wire logic                TIME_TICK,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  input  wire logic [15:0]         REG_ADDR,
  input  wire logic [15:0]         REG_WDATA,
  output logic [15:0]              REG_RDATA,
  input  wire logic                TRAP_IRQ_EN,
  input  wire logic                ROLLOVER_IRQ_EN,
  output logic                     TRAP_IRQ,
  output logic                     ROLLOVER_IRQ
);
  bcq_ctl_if ctl ();

  bcq_state_t          st_r;
  bcq_state_t          st_nxt;
  logic [`BCQ_OPW-1:0] op_r;
  logic [15:0]         param_r;
  logic [15:0]         list_addr_r;
  logic [15:0]         low_cap_r;
  logic [15:0]         cb_gap_r;
  logic [15:0]         time_lo_r;
  logic [15:0]         time_hi_r;
  logic [15:0]         time_cfg_r;
  logic                trig_prev_r;
  logic                done_r;
  logic                msg_start_r;
  logic                trap_nxt;
  logic                done_nxt;
  logic                msg_start_nxt;
  logic                issue_nxt;
  logic                we_nxt;
  logic [15:0]         addr_nxt;
  logic [15:0]         wdata_nxt;
  logic                take;
  logic                wide;
  logic                trig_rise;

  // Opcodes that push time and need the wide time base
  function automatic logic is_time_push(input logic [`BCQ_OPW-1:0] op);
    return (op == `BCQ_OP_PUSH_TIME_UPPER) || (op == `BCQ_OP_PUSH_TIME_PAIR);
  endfunction : is_time_push

  // Both flip opcodes share the message path
  function automatic logic is_flip(input logic [`BCQ_OPW-1:0] op);
    return (op == `BCQ_OP_EXEC_FLIP_WAIT) || (op == `BCQ_OP_EXEC_FLIP_GO);
  endfunction : is_flip

  bcq_gap_timer #(.TICK_CYCLES(TICK_CYCLES)) u_gap (
    .clk  (CLK),
    .srst (SRST),
    .ctl  (ctl.gap)
  );

  bcq_queue_ptr #(.DEPTH(QDEPTH)) u_que (
    .clk  (CLK),
    .srst (SRST),
    .ctl  (ctl.que)
  );

  assign OP_READY  = (st_r == BCQ_ST_IDLE);
  assign take      = OP_VALID && OP_READY;
  assign wide      = time_cfg_r[`BCQ_WIDE_TIME_BIT];
  // Edge seen against the previous sample, so a level already high waits
  assign trig_rise = EXT_TRIGGER && !trig_prev_r;
  assign GAP_ZERO  = ctl.gap_zero;
  assign OP_DONE   = done_r;
  assign MSG_START = msg_start_r;
  assign LIST_HALTED = (st_r == BCQ_ST_HALT);

  // Next state and the memory access to launch with it
  always_comb begin
    st_nxt           = st_r;
    issue_nxt        = 1'b0;
    we_nxt           = 1'b0;
    addr_nxt         = `BCQ_WORD_ZERO;
    wdata_nxt        = `BCQ_WORD_ZERO;
    done_nxt         = 1'b0;
    trap_nxt         = 1'b0;
    msg_start_nxt    = 1'b0;
    ctl.gap_load     = 1'b0;
    ctl.gap_value    = cb_gap_r;
    ctl.q_push       = 1'b0;
    case (st_r)
      BCQ_ST_IDLE: begin
        if (take) begin
          if (is_time_push(OP_CODE) && !wide) begin
            st_nxt   = BCQ_ST_HALT;
            trap_nxt = 1'b1;
          end else if (!is_flip(OP_CODE) && !COND_TRUE) begin
            done_nxt = 1'b1;
          end else begin
            case (OP_CODE)
              `BCQ_OP_PUSH_TIME_UPPER: begin
                issue_nxt = 1'b1;
                we_nxt    = 1'b1;
                addr_nxt  = ctl.q_addr;
                wdata_nxt = time_hi_r;
                st_nxt    = BCQ_ST_PUSH_B;
              end
              `BCQ_OP_PUSH_TIME_PAIR: begin
                issue_nxt = 1'b1;
                we_nxt    = 1'b1;
                addr_nxt  = ctl.q_addr;
                wdata_nxt = time_hi_r;
                st_nxt    = BCQ_ST_PUSH_A;
              end
              `BCQ_OP_PUSH_BLOCK_STAT: begin
                issue_nxt = 1'b1;
                we_nxt    = 1'b1;
                addr_nxt  = ctl.q_addr;
                wdata_nxt = BLOCK_STATUS;
                st_nxt    = BCQ_ST_PUSH_B;
              end
              `BCQ_OP_PUSH_IMMEDIATE: begin
                issue_nxt = 1'b1;
                we_nxt    = 1'b1;
                addr_nxt  = ctl.q_addr;
                wdata_nxt = OP_PARAM;
                st_nxt    = BCQ_ST_PUSH_B;
              end
              `BCQ_OP_PUSH_INDIRECT: begin
                issue_nxt = 1'b1;
                addr_nxt  = OP_PARAM;
                st_nxt    = BCQ_ST_RDIND;
              end
              `BCQ_OP_WAIT_TRIGGER: begin
                st_nxt = BCQ_ST_TRIG;
              end
              `BCQ_OP_EXEC_FLIP_WAIT, `BCQ_OP_EXEC_FLIP_GO: begin
                issue_nxt = 1'b1;
                addr_nxt  = OP_PARAM + `BCQ_CB_GAP_WORD;
                st_nxt    = BCQ_ST_RDCB;
              end
              default: begin
                done_nxt = 1'b1;
              end
            endcase
          end
        end
      end
      BCQ_ST_PUSH_A: begin
        if (MEM_ACK) begin
          ctl.q_push = 1'b1;
          issue_nxt  = 1'b1;
          we_nxt     = 1'b1;
          addr_nxt   = ctl.q_addr_next;
          wdata_nxt  = low_cap_r;
          st_nxt     = BCQ_ST_PUSH_B;
        end
      end
      BCQ_ST_PUSH_B: begin
        if (MEM_ACK) begin
          ctl.q_push = 1'b1;
          done_nxt   = 1'b1;
          st_nxt     = BCQ_ST_IDLE;
        end
      end
      BCQ_ST_RDIND: begin
        if (MEM_ACK) begin
          issue_nxt = 1'b1;
          we_nxt    = 1'b1;
          addr_nxt  = ctl.q_addr;
          wdata_nxt = MEM_RDATA;
          st_nxt    = BCQ_ST_PUSH_B;
        end
      end
      BCQ_ST_RDCB: begin
        if (MEM_ACK) begin
          st_nxt = BCQ_ST_PREGAP;
        end
      end
      BCQ_ST_PREGAP: begin
        if (ctl.gap_zero) begin
          msg_start_nxt = 1'b1;
          ctl.gap_load  = (cb_gap_r != `BCQ_WORD_ZERO);
          st_nxt        = BCQ_ST_MSG;
        end
      end
      BCQ_ST_MSG: begin
        if (MSG_DONE) begin
          if (COND_TRUE) begin
            issue_nxt = 1'b1;
            we_nxt    = 1'b1;
            addr_nxt  = list_addr_r;
            wdata_nxt = param_r ^ `BCQ_FLIP_MASK;
            st_nxt    = BCQ_ST_WBACK;
          end else if (op_r == `BCQ_OP_EXEC_FLIP_WAIT) begin
            st_nxt = BCQ_ST_GAPWT;
          end else begin
            done_nxt = 1'b1;
            st_nxt   = BCQ_ST_IDLE;
          end
        end
      end
      BCQ_ST_WBACK: begin
        if (MEM_ACK) begin
          if (op_r == `BCQ_OP_EXEC_FLIP_WAIT) begin
            st_nxt = BCQ_ST_GAPWT;
          end else begin
            done_nxt = 1'b1;
            st_nxt   = BCQ_ST_IDLE;
          end
        end
      end
      BCQ_ST_GAPWT: begin
        if (ctl.gap_zero) begin
          done_nxt = 1'b1;
          st_nxt   = BCQ_ST_IDLE;
        end
      end
      BCQ_ST_TRIG: begin
        if (trig_rise) begin
          done_nxt = 1'b1;
          st_nxt   = BCQ_ST_IDLE;
        end
      end
      BCQ_ST_HALT: begin
        if (LIST_RESTART) begin
          st_nxt = BCQ_ST_IDLE;
        end
      end
      default: begin
        st_nxt = BCQ_ST_IDLE;
      end
    endcase
  end

  // Sequencer state and its one-cycle strobes
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_r        <= BCQ_ST_IDLE;
      done_r      <= 1'b0;
      msg_start_r <= 1'b0;
      TRAP_IRQ    <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      done_r      <= done_nxt;
      msg_start_r <= msg_start_nxt;
      TRAP_IRQ    <= trap_nxt && TRAP_IRQ_EN;
    end
  end

  // RAM request holds until acknowledged; a new issue replaces it
  always_ff @(posedge CLK) begin
    if (SRST) begin
      MEM_REQ   <= 1'b0;
      MEM_WE    <= 1'b0;
      MEM_ADDR  <= `BCQ_WORD_ZERO;
      MEM_WDATA <= `BCQ_WORD_ZERO;
    end else if (issue_nxt) begin
      MEM_REQ   <= 1'b1;
      MEM_WE    <= we_nxt;
      MEM_ADDR  <= addr_nxt;
      MEM_WDATA <= wdata_nxt;
    end else if (MEM_ACK) begin
      MEM_REQ   <= 1'b0;
      MEM_WE    <= 1'b0;
    end
  end

  // Opcode capture; both time words taken in the same edge
  always_ff @(posedge CLK) begin
    if (SRST) begin
      op_r           <= '0;
      param_r        <= `BCQ_WORD_ZERO;
      list_addr_r    <= `BCQ_WORD_ZERO;
      low_cap_r      <= `BCQ_WORD_ZERO;
      cb_gap_r       <= `BCQ_WORD_ZERO;
      MSG_BLOCK_ADDR <= `BCQ_WORD_ZERO;
    end else begin
      if (take) begin
        op_r           <= OP_CODE;
        param_r        <= OP_PARAM;
        list_addr_r    <= OP_PARAM_ADDR;
        low_cap_r      <= time_lo_r;
        MSG_BLOCK_ADDR <= OP_PARAM;
      end
      if (st_r == BCQ_ST_RDCB && MEM_ACK) begin
        cb_gap_r <= MEM_RDATA;
      end
    end
  end

  // Trigger history follows the pin through reset as well, so a pin that
  // idles high is not mistaken for a rising edge once reset lifts
  always_ff @(posedge CLK) begin
    trig_prev_r <= EXT_TRIGGER;
  end

  // Time count: host write wins over a tick; upper counts only in wide mode
  always_ff @(posedge CLK) begin
    if (SRST) begin
      time_lo_r  <= `BCQ_WORD_ZERO;
      time_hi_r  <= `BCQ_WORD_ZERO;
      time_cfg_r <= `BCQ_WORD_ZERO;
    end else begin
      if (REG_WR && REG_ADDR == `BCQ_REG_TIME_CONFIG) begin
        time_cfg_r <= REG_WDATA;
      end
      if (REG_WR && REG_ADDR == `BCQ_REG_TIME_LOW) begin
        time_lo_r <= REG_WDATA;
      end else if (TIME_TICK) begin
        time_lo_r <= time_lo_r + `BCQ_WORD_ONE;
      end
      if (REG_WR && REG_ADDR == `BCQ_REG_TIME_HIGH) begin
        time_hi_r <= REG_WDATA;
      end else if (TIME_TICK && wide && time_lo_r == `BCQ_WORD_ALL) begin
        time_hi_r <= time_hi_r + `BCQ_WORD_ONE;
      end
    end
  end

  assign ctl.q_host_wr   = REG_WR && (REG_ADDR == `BCQ_REG_QUEUE_PTR);
  assign ctl.q_host_data = REG_WDATA;

  // Registered read port; unmapped offsets read zero
  always_ff @(posedge CLK) begin
    if (SRST) begin
      REG_RDATA <= `BCQ_WORD_ZERO;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `BCQ_REG_GAP_COUNT:   REG_RDATA <= ctl.gap_count;
        `BCQ_REG_QUEUE_PTR:   REG_RDATA <= ctl.q_addr;
        `BCQ_REG_TIME_CONFIG: REG_RDATA <= time_cfg_r;
        `BCQ_REG_TIME_LOW:    REG_RDATA <= time_lo_r;
        `BCQ_REG_TIME_HIGH:   REG_RDATA <= time_hi_r;
        default:              REG_RDATA <= `BCQ_WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ROLLOVER_IRQ <= 1'b0;
    end else begin
      ROLLOVER_IRQ <= ctl.q_wrap && ROLLOVER_IRQ_EN;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  property p_trap;
    take && is_time_push(OP_CODE) && !wide |=> LIST_HALTED && !MEM_REQ;
  endproperty
  a_trap: assert property (p_trap) else $error("illegal time push not halted");

  property p_false_cond;
    take && !is_flip(OP_CODE) && !COND_TRUE && !is_time_push(OP_CODE) |=> OP_DONE && !MEM_REQ;
  endproperty
  a_false_cond: assert property (p_false_cond) else $error("false condition acted");

  property p_push_imm;
    take && COND_TRUE && OP_CODE == `BCQ_OP_PUSH_IMMEDIATE
      |=> MEM_REQ && MEM_WE && MEM_WDATA == $past(OP_PARAM) && MEM_ADDR == $past(ctl.q_addr);
  endproperty
  a_push_imm: assert property (p_push_imm) else $error("immediate push wrong");

  property p_pair_order;
    st_r == BCQ_ST_PUSH_A && MEM_ACK |=> MEM_REQ && MEM_WE && MEM_WDATA == low_cap_r;
  endproperty
  a_pair_order: assert property (p_pair_order) else $error("pair second word wrong");

  property p_trig_hold;
    st_r == BCQ_ST_TRIG && !trig_rise |=> st_r == BCQ_ST_TRIG && !OP_DONE;
  endproperty
  a_trig_hold: assert property (p_trig_hold) else $error("left trigger wait early");

  property p_start_gap;
    MSG_START |-> $past(ctl.gap_zero) && $past(st_r) == BCQ_ST_PREGAP;
  endproperty
  a_start_gap: assert property (p_start_gap) else $error("message started during gap");

  property p_gap_load;
    MSG_START && cb_gap_r != `BCQ_WORD_ZERO |-> ctl.gap_count == cb_gap_r;
  endproperty
  a_gap_load: assert property (p_gap_load) else $error("gap word not loaded");

  property p_flip_wb;
    st_r == BCQ_ST_MSG && MSG_DONE && COND_TRUE
      |=> MEM_WE && MEM_WDATA == (param_r ^ `BCQ_FLIP_MASK) && MEM_ADDR == list_addr_r;
  endproperty
  a_flip_wb: assert property (p_flip_wb) else $error("flip write back wrong");

  property p_no_flip;
    st_r == BCQ_ST_MSG && MSG_DONE && !COND_TRUE |=> !MEM_REQ;
  endproperty
  a_no_flip: assert property (p_no_flip) else $error("parameter changed on false");

  property p_wait_gap;
    st_r == BCQ_ST_GAPWT && !ctl.gap_zero |=> !OP_DONE;
  endproperty
  a_wait_gap: assert property (p_wait_gap) else $error("fetch before gap zero");

  property p_rollover;
    ctl.q_wrap && ROLLOVER_IRQ_EN |=> ROLLOVER_IRQ;
  endproperty
  a_rollover: assert property (p_rollover) else $error("rollover interrupt missing");

  c_pair: cover property (st_r == BCQ_ST_PUSH_A ##[1:20] OP_DONE);
  c_trig: cover property (st_r == BCQ_ST_TRIG ##[1:50] OP_DONE);
  c_flip: cover property (MSG_START ##[1:200] st_r == BCQ_ST_WBACK);
  c_wrap: cover property (ctl.q_wrap);
endmodule : bcq_exec

// [testbench/bcq_ram_model.sv]
// Behavioural RAM answering the block's memory port.
// Assumes requests are held until acknowledged; dly sets answer latency.
`timescale 1ns/1ps
module bcq_ram_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  dly,
  output logic [15:0]      rdata,
  output logic             ack
);
  logic [15:0] mem [0:255];
  logic [1:0]  cnt = 2'h0;
  initial ack = 1'b0;
  initial rdata = 16'h5A5A;
  // Data is scrambled outside the ack cycle so stale reads never match
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req && !ack) begin
      if (cnt == dly) begin
        ack <= 1'b1;
        cnt <= 2'h0;
        rdata <= mem[addr[7:0]];
        if (we) mem[addr[7:0]] <= wdata;
      end else cnt <= cnt + 2'h1;
    end
  end
endmodule : bcq_ram_model

// [testbench/bc_queue_push_and_flip_ops_bench.sv]
// Self-checking bench: queue model with expected RAM writes and irq counts.
// Assumes the RAM model and a three-cycle message engine stand in.
`timescale 1ns/1ps
`define CHK(a,b) begin n_tests++; if ((a)!==(b)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module bc_queue_push_and_flip_ops_bench;
  logic CLK=0, SRST=1, OP_VALID=0, COND_TRUE=0, LIST_RESTART=0, EXT_TRIGGER=0;
  logic MSG_DONE=0, TIME_TICK=0, REG_WR=0, REG_RD=0, TRAP_IRQ_EN=1, ROLLOVER_IRQ_EN=1;
  logic OP_READY, OP_DONE, LIST_HALTED, MEM_REQ, MEM_WE, MEM_ACK, MSG_START;
  logic GAP_ZERO, TRAP_IRQ, ROLLOVER_IRQ;
  logic [4:0]  OP_CODE=0;
  logic [1:0]  dly=0, mcnt=0;
  logic [15:0] OP_PARAM=0, OP_PARAM_ADDR=0, BLOCK_STATUS=0, REG_ADDR=0, REG_WDATA=0;
  logic [15:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, MSG_BLOCK_ADDR, REG_RDATA, d, qp=16'h00C0;
  logic [31:0] s=32'h40e2, r, gv, ev, got[$], exp[$];
  logic [4:0]  fo [0:5] = '{5'h12, 5'h11, 5'h13, 5'h19, 5'h1A, 5'h14};
  int err_count=0, n_tests=0, cyc=0, trap_n=0, roll_n=0, roll_e=0, msg_n=0, k, i;
  bcq_exec #(.TICK_CYCLES(2)) dut (.*);
  bcq_ram_model ram (.clk(CLK), .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR),
    .wdata(MEM_WDATA), .dly(dly), .rdata(MEM_RDATA), .ack(MEM_ACK));
  always #25 CLK = ~CLK;
  function automatic logic [31:0] xs();
    s ^= s << 13; s ^= s >> 17; s ^= s << 5; return s;
  endfunction : xs
  task conclude;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // Records writes and pulses, plays the message engine, cuts hangs short
  always @(posedge CLK) begin
    if (MEM_REQ && MEM_WE && MEM_ACK) got.push_back({MEM_ADDR, MEM_WDATA});
    if (TRAP_IRQ) trap_n++;
    if (ROLLOVER_IRQ) roll_n++;
    MSG_DONE <= (mcnt == 2'h1);
    if (MSG_START) mcnt <= 2'h3; else if (mcnt != 0) mcnt <= mcnt - 2'h1;
    if (MSG_START) msg_n++;
    if (++cyc > 30000) begin err_count++; conclude(); end
  end
  task push(input logic [15:0] v);
    exp.push_back({qp, v});
    if (qp == 16'h00FF) begin qp = 16'h00C0; roll_e++; end else qp++;
  endtask : push
  task cmpq;
    while (exp.size() > 0) begin
      ev = exp.pop_front();
      gv = got.pop_front();
      `CHK(gv, ev)
    end
    `CHK(got.size(), 0)
  endtask : cmpq
  task op(input logic [4:0] c, input logic [15:0] p, input logic t, output int n);
    @(posedge CLK); OP_VALID <= 1; OP_CODE <= c; OP_PARAM <= p; COND_TRUE <= t;
    do @(posedge CLK); while (!OP_READY);
    OP_VALID <= 0;
    for (n = 0; n < 200 && !OP_DONE; n++) @(posedge CLK);
  endtask : op
  task rw(input logic w, input logic [15:0] a, v);
    @(posedge CLK); REG_WR <= w; REG_RD <= !w; REG_ADDR <= a; REG_WDATA <= v;
    @(posedge CLK); REG_WR <= 0; REG_RD <= 0;
    #1 d = REG_RDATA;
  endtask : rw
  initial begin
    repeat (16) @(posedge CLK);
    SRST <= 0;
    rw(0, 16'h0036, 0); `CHK(d, 16'h0000)
    rw(0, 16'h0077, 0); `CHK(d, 16'h0000)
    r = xs(); dly <= r[1:0];
    op(5'h12, r[15:0], 1, k); push(r[15:0]);
    BLOCK_STATUS <= r[31:16]; op(5'h11, 0, 1, k); push(r[31:16]);
    ram.mem[8'h40] = ~r[15:0]; op(5'h13, 16'h0040, 1, k); push(~r[15:0]);
    op(5'h19, 0, 1, k); `CHK(LIST_HALTED, 1'b1)
    `CHK(trap_n, 1)
    @(posedge CLK); LIST_RESTART <= 1; @(posedge CLK); LIST_RESTART <= 0;
    rw(1, 16'h0039, 16'h0008); rw(1, 16'h0043, r[15:0]); rw(1, 16'h0044, r[31:16]);
    op(5'h1A, 0, 1, k); push(r[31:16]); push(r[15:0]);
    op(5'h19, 0, 1, k); push(r[31:16]);
    for (i = 0; i < 6; i++) begin
      op(fo[i], 16'h0040, 0, k);
      `CHK(k, 1)
    end
    cmpq();
    fork op(5'h14, 0, 1, k); begin repeat (6) @(posedge CLK); EXT_TRIGGER <= 1; end join
    EXT_TRIGGER <= 0; `CHK(k > 4, 1'b1)
    dly <= 0;
    for (i = 0; i < 2; i++) begin
      ram.mem[8'h83] = 16'h0010; OP_PARAM_ADDR <= 16'h00A0 + i;
      op(i ? 5'h17 : 5'h15, 16'h0080, i, k);
      if (i) exp.push_back({16'h00A1, 16'h0090});
      `CHK(GAP_ZERO, !i)
    end
    op(5'h12, 16'h00AB, 1, k); push(16'h00AB); `CHK(GAP_ZERO, 1'b0)
    op(5'h17, 16'h0080, 0, k); `CHK(k > 15, 1'b1)
    `CHK(msg_n, 3)
    `CHK(MSG_BLOCK_ADDR, 16'h0080)
    repeat (64) begin r = xs(); op(5'h12, r[15:0], 1, k); push(r[15:0]); end
    cmpq(); `CHK(roll_n, roll_e)
    conclude();
  end
endmodule : bc_queue_push_and_flip_ops_bench
